/* inc/exec_pkg.sv */
/*
 * Shared constants for the OR-with-register and pointer-load execution logic.
 * Assumes a core that hands over one 16-bit instruction word per four-phase cycle.
 */
package exec_pkg;
    // ------------------------------------------------------------
    // Instruction phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_type;

    // ------------------------------------------------------------
    // Encodings and fields
    // ------------------------------------------------------------
    localparam logic [5:0] OR_REG_OPC = 6'h04;
    localparam logic [9:0] PTR_LOAD_OPC = 10'h3B8;
    localparam logic [3:0] PTR_LOAD_WORD2 = 4'hF;
    localparam int OPC_HI = 15;
    localparam int OR_OPC_LO = 10;
    localparam int PTR_OPC_LO = 6;
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    localparam int PSEL_HI = 5;
    localparam int PSEL_LO = 4;
    localparam int WORD2_LO = 12;
    localparam logic [1:0] PTR_LAST = 2'h2;
    localparam int PTR_COUNT = 3;
    localparam int INDEX_PTR = 2;

    // ------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

    // ------------------------------------------------------------
    // Register port map
    // ------------------------------------------------------------
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_BANK = 3'h1;
    localparam logic [2:0] REG_ACC = 3'h2;
    localparam logic [2:0] REG_PTR0 = 3'h3;
    localparam logic [2:0] REG_PTR1 = 3'h4;
    localparam logic [2:0] REG_PTR2 = 3'h5;
    localparam logic [2:0] REG_STAT = 3'h6;
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [11:0] PTR_RESET = 12'h000;
endpackage

/* inc/operand_if.sv */
/*
 * Carries the operand field and addressing state to the address calculator.
 * Assumes the calculator answers combinationally.
 */
`timescale 1ns/1ps
interface operand_if;
    logic [7:0] f;
    logic a;
    logic ext_en;
    logic [3:0] bank;
    logic [11:0] index_base;
    logic [11:0] addr;
    modport core (output f, a, ext_en, bank, index_base, input addr);
    modport calc (input f, a, ext_en, bank, index_base, output addr);
endinterface

/* hdl/operand_addr_gen.sv */
/*
 * Effective data-memory address for a byte-oriented operand.
 * Assumes the core supplies the bank and index pointer values that are current.
 */
`timescale 1ns/1ps
module operand_addr_gen
    import exec_pkg::*;
(
    operand_if.calc op
);
    always_comb begin
        if (op.a) begin
            op.addr = {op.bank, op.f};
        end else if (op.ext_en && (op.f <= INDEX_LIMIT)) begin
            op.addr = op.index_base + {4'h0, op.f};
        end else if (op.f >= ACCESS_SPLIT) begin
            op.addr = {ACCESS_HI_BANK, op.f};
        end else begin
            op.addr = {ACCESS_LO_BANK, op.f};
        end
    end
endmodule

/* hdl/or_pointer_exec.sv */
/*
 * Execution of the register-OR and pointer-load instructions over a four-phase
 * instruction cycle, with a small software register port.
 * Assumes instr_i is stable from the Q1 edge, and that data memory answers a
 * read strobed in Q2 with dm_rdata_i during Q3.
 */
// The placing of the registers and strobed register access were chosen for this implementation.
// Functional notes
// - The pointer load writes its 12-bit literal into the pointer chosen by its two-bit field.
// - Only pointer indexes 0 to 2 are loaded; literals span 0 to 4095.
// - The upper four literal bits go to the high nibble and the lower eight to the low byte.
// - Access bit zero addresses the access bank; one uses the bank select register.
// - Access bit zero, extended set on and operand at most 95 selects indexed literal offset.
// - The register OR decodes in Q1, reads in Q2, processes in Q3, writes in Q4, one cycle.
// - With destination zero the register stays unchanged and the OR goes to the accumulator.
// - Destination zero routes the result to the accumulator, one writes it back to the register.
`timescale 1ns/1ps
module or_pointer_exec
    import exec_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [15:0] instr_i,
    output logic [11:0] dm_addr_o,
    output logic dm_rd_o,
    input wire logic [7:0] dm_rdata_i,
    output logic dm_wr_o,
    output logic [7:0] dm_wdata_o,
    output logic [1:0] phase_o,
    input wire logic [2:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [15:0] reg_rdata_o
);
    phase_type phase_q;
    logic [15:0] instr_q;
    logic word2_q;
    logic [1:0] psel_q;
    logic [11:0] ptr_q [PTR_COUNT];
    logic [7:0] acc_q;
    logic [7:0] result_q;
    logic neg_q;
    logic zero_q;
    logic ext_en_q;
    logic [3:0] bank_q;
    logic [11:0] dm_addr_q;
    logic dm_rd_q;
    logic dm_wr_q;
    logic [7:0] dm_wdata_q;
    logic [15:0] rdata_q;
    logic or_now;
    logic or_op;
    logic ptr_op;
    logic [7:0] or_value;
    operand_if op ();

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign or_now = !word2_q && (instr_i[OPC_HI:OR_OPC_LO] == OR_REG_OPC);
    assign or_op = !word2_q && (instr_q[OPC_HI:OR_OPC_LO] == OR_REG_OPC);
    // index 3 is not a pointer load
    assign ptr_op = !word2_q && (instr_q[OPC_HI:PTR_OPC_LO] == PTR_LOAD_OPC)
        && (instr_q[PSEL_HI:PSEL_LO] <= PTR_LAST);
    assign or_value = acc_q | dm_rdata_i;

    assign op.f = instr_i[7:0];
    assign op.a = instr_i[ACCESS_BIT];
    assign op.ext_en = ext_en_q;
    assign op.bank = bank_q;
    assign op.index_base = ptr_q[INDEX_PTR];

    operand_addr_gen u_addr (
        .op(op.calc)
    );

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    // one instruction per four phases
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_q <= PH_Q1;
        end else begin
            case (phase_q)
                PH_Q1: phase_q <= PH_Q2;
                PH_Q2: phase_q <= PH_Q3;
                PH_Q3: phase_q <= PH_Q4;
                default: phase_q <= PH_Q1;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            instr_q <= 16'h0000;
        end else if (phase_q == PH_Q1) begin
            instr_q <= instr_i;
        end
    end

    // ------------------------------------------------------------
    // Register OR datapath
    // ------------------------------------------------------------
    // read strobe in Q2, write strobe in Q4
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            dm_addr_q <= 12'h000;
            dm_rd_q <= 1'b0;
            dm_wr_q <= 1'b0;
            dm_wdata_q <= 8'h00;
            result_q <= 8'h00;
        end else begin
            dm_rd_q <= 1'b0;
            dm_wr_q <= 1'b0;
            if (phase_q == PH_Q1) begin
                dm_addr_q <= op.addr;
                dm_rd_q <= or_now;
            end
            if ((phase_q == PH_Q3) && or_op) begin
                result_q <= or_value;
                dm_wdata_q <= or_value;
                dm_wr_q <= instr_q[DEST_BIT];
            end
        end
    end

    // Core update wins over a software write in the same cycle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= ACC_RESET;
        end else if ((phase_q == PH_Q4) && or_op && !instr_q[DEST_BIT]) begin
            acc_q <= result_q;
        end else if (reg_we_i && (reg_addr_i == REG_ACC)) begin
            acc_q <= reg_wdata_i[7:0];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            neg_q <= 1'b0;
            zero_q <= 1'b0;
        end else if ((phase_q == PH_Q4) && or_op) begin
            neg_q <= result_q[7];
            zero_q <= (result_q == 8'h00);
        end
    end

    // ------------------------------------------------------------
    // Pointer load
    // ------------------------------------------------------------
    // high nibble on word one, low byte on word two
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            word2_q <= 1'b0;
            psel_q <= 2'h0;
            for (int i = 0; i < PTR_COUNT; i++) begin
                ptr_q[i] <= PTR_RESET;
            end
        end else if (phase_q == PH_Q4) begin
            if (ptr_op) begin
                psel_q <= instr_q[PSEL_HI:PSEL_LO];
                ptr_q[instr_q[PSEL_HI:PSEL_LO]][11:8] <= instr_q[3:0];
                word2_q <= 1'b1;
            end else if (word2_q) begin
                ptr_q[psel_q][7:0] <= instr_q[7:0];
                word2_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_en_q <= CTRL_RESET;
            bank_q <= BANK_RESET;
        end else if (reg_we_i) begin
            if (reg_addr_i == REG_CTRL) begin
                ext_en_q <= reg_wdata_i[0];
            end else if (reg_addr_i == REG_BANK) begin
                bank_q <= reg_wdata_i[3:0];
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 16'h0000;
        end else if (reg_re_i) begin
            if (reg_addr_i == REG_CTRL) begin
                rdata_q <= {15'h0000, ext_en_q};
            end else if (reg_addr_i == REG_BANK) begin
                rdata_q <= {12'h000, bank_q};
            end else if (reg_addr_i == REG_ACC) begin
                rdata_q <= {8'h00, acc_q};
            end else if (reg_addr_i == REG_PTR0) begin
                rdata_q <= {4'h0, ptr_q[0]};
            end else if (reg_addr_i == REG_PTR1) begin
                rdata_q <= {4'h0, ptr_q[1]};
            end else if (reg_addr_i == REG_PTR2) begin
                rdata_q <= {4'h0, ptr_q[2]};
            end else if (reg_addr_i == REG_STAT) begin
                rdata_q <= {13'h0000, word2_q, neg_q, zero_q};
            end else begin
                rdata_q <= 16'h0000;
            end
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign dm_addr_o = dm_addr_q;
    assign dm_rd_o = dm_rd_q;
    assign dm_wr_o = dm_wr_q;
    assign dm_wdata_o = dm_wdata_q;
    assign phase_o = phase_q;
    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    AST_PTR_LOW: assert property (
        ((phase_q == PH_Q4) && word2_q) |=> (ptr_q[$past(psel_q)][7:0] == $past(instr_q[7:0])))
        else $error("pointer low byte not loaded from second word");
    AST_PTR_INDEX: assert property (
        ((phase_q == PH_Q4) && !word2_q && (instr_q[OPC_HI:PTR_OPC_LO] == PTR_LOAD_OPC)
        && (instr_q[PSEL_HI:PSEL_LO] > PTR_LAST))
        |=> (!word2_q && $stable(ptr_q[0]) && $stable(ptr_q[1]) && $stable(ptr_q[2])))
        else $error("pointer index three accepted");
    AST_PTR_HIGH: assert property (
        ((phase_q == PH_Q4) && ptr_op) |=> ##4 (ptr_q[psel_q][11:8] == $past(instr_q[3:0], 5)))
        else $error("pointer high nibble wrong");
    AST_BANKED: assert property (
        ((phase_q == PH_Q1) && or_now && instr_i[ACCESS_BIT])
        |=> (dm_addr_o == {$past(bank_q), $past(instr_i[7:0])}))
        else $error("banked operand address wrong");
    AST_INDEXED: assert property (
        ((phase_q == PH_Q1) && or_now && !instr_i[ACCESS_BIT] && ext_en_q && (instr_i[7:0] <= INDEX_LIMIT))
        |=> (dm_addr_o == $past(ptr_q[INDEX_PTR]) + {4'h0, $past(instr_i[7:0])}))
        else $error("indexed operand address wrong");
    AST_OR_TIMING: assert property (
        ((phase_q == PH_Q1) && or_now) |=> dm_rd_o ##1 !dm_rd_o ##1 (dm_wr_o == instr_q[DEST_BIT]))
        else $error("register OR phases wrong");
    AST_TO_ACC: assert property (
        ((phase_q == PH_Q3) && or_op && !instr_q[DEST_BIT])
        |=> !dm_wr_o ##1 (acc_q == $past(result_q)))
        else $error("accumulator not updated or register written");
    AST_TO_REG: assert property (
        ((phase_q == PH_Q3) && or_op && instr_q[DEST_BIT])
        |=> (dm_wr_o && (dm_wdata_o == $past(or_value)) && $stable(acc_q)))
        else $error("register write-back wrong");

    COV_OR_ACC: cover property ((phase_q == PH_Q4) && or_op && !instr_q[DEST_BIT]);
    COV_OR_REG: cover property (dm_wr_o);
    COV_PTR_LOAD: cover property ((phase_q == PH_Q4) && word2_q);
    COV_INDEXED: cover property ((phase_q == PH_Q1) && or_now && !instr_i[ACCESS_BIT] && ext_en_q);
endmodule

/* bench/or_and_pointer_load_exec_test.sv */
/*
 * Self-checking bench for the register-OR and pointer-load execution block.
 * Assumes the bench stands in for data memory and drives the register port itself.
 */
`timescale 1ns/1ps
module or_and_pointer_load_exec_test
    import exec_pkg::*;
;
    logic mclk_i;
    logic rst_i;
    logic [15:0] instr_i;
    logic [11:0] dm_addr_o;
    logic dm_rd_o;
    logic [7:0] dm_rdata_i;
    logic dm_wr_o;
    logic [7:0] dm_wdata_o;
    logic [1:0] phase_o;
    logic [2:0] reg_addr_i;
    logic [15:0] reg_wdata_i;
    logic reg_we_i;
    logic reg_re_i;
    logic [15:0] reg_rdata_o;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;

    or_pointer_exec uut (.mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i), .dm_addr_o(dm_addr_o),
        .dm_rd_o(dm_rd_o), .dm_rdata_i(dm_rdata_i), .dm_wr_o(dm_wr_o), .dm_wdata_o(dm_wdata_o),
        .phase_o(phase_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Well above the roughly 150 cycles the tests need
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_we_i <= 1'b0;
    endtask

    task automatic reg_chk(input string what, input logic [2:0] a, input logic [15:0] exp);
        @(posedge mclk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_re_i <= 1'b0;
        @(negedge mclk_i);
        check(what, reg_rdata_o, exp);
    endtask

    // Word lands one cycle before the Q1 edge that takes it
    task automatic issue(input logic [15:0] w);
        @(negedge mclk_i);
        while (phase_o !== PH_Q4) @(negedge mclk_i);
        @(posedge mclk_i);
        instr_i <= w;
    endtask

    task automatic run_or(input string what, input logic [15:0] w, input logic [7:0] rd,
                          input logic [11:0] ea, input logic [7:0] ed);
        issue(w);
        @(negedge mclk_i);
        check({what, " rd q1"}, dm_rd_o, 1'b0);
        @(negedge mclk_i);
        check({what, " rd q2"}, dm_rd_o, 1'b1);
        check({what, " phase q2"}, phase_o, PH_Q2);
        check({what, " addr"}, dm_addr_o, ea);
        @(posedge mclk_i);
        dm_rdata_i <= rd;
        instr_i <= 16'h0000;
        @(posedge mclk_i);
        // Stale read data is inverted so a late sample shows up
        dm_rdata_i <= ~rd;
        @(negedge mclk_i);
        check({what, " wr q4"}, dm_wr_o, w[DEST_BIT]);
        if (w[DEST_BIT]) check({what, " wdata"}, dm_wdata_o, ed);
        @(negedge mclk_i);
        check({what, " wr after"}, dm_wr_o, 1'b0);
    endtask

    task automatic load_ptr(input logic [1:0] sel, input logic [11:0] k);
        issue({PTR_LOAD_OPC, sel, k[11:8]});
        repeat (4) @(posedge mclk_i);
        instr_i <= {8'hF0, k[7:0]};
        repeat (4) @(posedge mclk_i);
        instr_i <= 16'h0000;
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic test_reset_values();
        reg_chk("acc reset", REG_ACC, 16'h0000);
        reg_chk("ptr0 reset", REG_PTR0, 16'h0000);
        reg_chk("ptr2 reset", REG_PTR2, 16'h0000);
        reg_chk("unmapped", 3'h7, 16'h0000);
        $display("test reset values done");
    endtask

    task automatic test_pointer_load();
        load_ptr(2'h0, 12'hFFF);
        load_ptr(2'h1, 12'h5A5);
        load_ptr(2'h2, 12'h3AB);
        load_ptr(2'h3, 12'h123);
        reg_chk("ptr0", REG_PTR0, 16'h0FFF);
        reg_chk("ptr1", REG_PTR1, 16'h05A5);
        reg_chk("ptr2", REG_PTR2, 16'h03AB);
        $display("test pointer load done");
    endtask

    task automatic test_or_dest();
        reg_wr(REG_BANK, 16'h0005);
        reg_wr(REG_ACC, 16'h0091);
        run_or("or to acc", 16'h1134, 8'h13, 12'h534, 8'h00);
        reg_chk("acc after or", REG_ACC, 16'h0093);
        reg_chk("status n z", REG_STAT, 16'h0002);
        run_or("or to reg", 16'h1334, 8'h40, 12'h534, 8'hD3);
        reg_chk("acc kept", REG_ACC, 16'h0093);
        $display("test or destination done");
    endtask

    task automatic test_or_access();
        run_or("access hi", 16'h1290, 8'h00, 12'hF90, 8'h93);
        run_or("access lo", 16'h127F, 8'h00, 12'h07F, 8'h93);
        run_or("ext off", 16'h125F, 8'h00, 12'h05F, 8'h93);
        reg_wr(REG_CTRL, 16'h0001);
        run_or("indexed", 16'h125F, 8'h04, 12'h40A, 8'h97);
        run_or("past index", 16'h1260, 8'h00, 12'h060, 8'h93);
        run_or("bank wins", 16'h1320, 8'h00, 12'h520, 8'h93);
        $display("test or access done");
    endtask

    initial begin
        rst_i = 1'b1;
        instr_i = 16'h0000;
        dm_rdata_i = 8'h00;
        reg_addr_i = 3'h0;
        reg_wdata_i = 16'h0000;
        reg_we_i = 1'b0;
        reg_re_i = 1'b0;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        test_reset_values();
        test_pointer_load();
        test_or_dest();
        test_or_access();
        test_done();
    end
endmodule
